// *** hw/adia_consts.svh ***
// constants for the analog die interrupt aggregator
`ifndef ADIA_CONSTS_SVH
`define ADIA_CONSTS_SVH
`define ADIA_NUM_SRC 14
`define ADIA_OFS_SRC_HI 8'h08
`define ADIA_OFS_SRC_LO 8'h09
`define ADIA_OFS_VECT 8'h0a
`define ADIA_OFS_RSVD 8'h0b
`define ADIA_OFS_MSK_HI 8'h0c
`define ADIA_OFS_MSK_LO 8'h0d
`define ADIA_OFS_PSR 8'h10
`define ADIA_OFS_CTRL 8'h11
`define ADIA_BIT_UVF 6
`define ADIA_BIT_HTF 7
`define ADIA_MSK_RESET 14'h3fff
`define ADIA_SRC_UV 0
`define ADIA_SRC_HT 1
`define ADIA_SRC_LT 2
`endif

// *** hw/adia_pkg.sv ***
// types for the analog die interrupt aggregator
package adia_pkg;
  typedef logic [13:0] adia_src_t;
  typedef enum logic [2:0] {
    ADIA_IDLE = 3'h1,
    ADIA_REQ = 3'h2,
    ADIA_DONE = 3'h4
  } adia_mst_state_t;
endpackage

// *** hw/adia_d2d_if.sv ***
// die-to-die register link and interrupt line between the two ends
`timescale 1ns/1ps
interface adia_d2d_if;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [7:0] dat_w;
  logic [7:0] dat_r;
  logic ack;
  logic die_interrupt_line;
  modport device (input cyc, input stb, input we, input adr, input dat_w,
    output dat_r, output ack, output die_interrupt_line);
  modport host (output cyc, output stb, output we, output adr, output dat_w,
    input dat_r, input ack, input die_interrupt_line);
endinterface

// *** hw/adia_device.sv ***
// analog die interrupt aggregator, die side
`timescale 1ns/1ps
`include "adia_consts.svh"
// Operation
// RQ1: all events drive one die interrupt line
// RQ2: read-only mirror shows every pending source
// RQ3: mirror read acknowledges nothing
// RQ4: vector reads highest pending source number; the code reports the lowest pending bit number plus one
// RQ5: vector read acknowledges nothing
// RQ6: high and low global masks gate sources
// RQ7: fourteen listed sources, fixed bit order
// RQ8: under-voltage acknowledged by writing flag one
// RQ9: acknowledge ignored while condition persists
// RQ10: new interrupt only after condition re-appears
// RQ11: status flags show the live condition
// RQ12: cranking mode disables under-voltage interrupt
// RQ13: cranking wake-up sets under-voltage pending
// RQ14: high temperature acknowledged by writing one
// RQ15: line is level while unmasked pending
// RQ16: fixed priority, vector zero when none
module adia_device (
  input wire logic sys_clk,
  input wire logic rst,
  adia_d2d_if.device bus,
  input wire logic supply_input_low,
  input wire logic high_temp_cond,
  input wire logic cranking_en,
  input wire logic cranking_wake,
  input wire logic [11:0] block_irq,
  output logic undervoltage_flag,
  output logic high_temp_flag,
  output logic precision_lv_en
);
  adia_pkg::adia_src_t pend_q;
  adia_pkg::adia_src_t pend_d;
  adia_pkg::adia_src_t msk_q;
  adia_pkg::adia_src_t msk_d;
  logic uv_prev_q;
  logic uv_prev_d;
  logic ht_prev_q;
  logic ht_prev_d;
  logic uvf_q;
  logic uvf_d;
  logic htf_q;
  logic htf_d;
  logic plv_q;
  logic plv_d;
  logic irq_q;
  logic irq_d;
  logic ack_q;
  logic ack_d;
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;
  logic [3:0] vect;
  logic acc;
  logic rd;
  logic wr;
  logic psr_wr;
  logic uv_ack;
  logic ht_ack;
  logic uv_rise;
  logic ht_rise;

  // a new request is taken only while no answer is out
  assign acc = bus.cyc && bus.stb && !ack_q;
  assign rd = acc && !bus.we;
  // writes land on the edge at which the host sees the answer
  assign wr = bus.cyc && bus.stb && bus.we && ack_q;
  assign psr_wr = wr && bus.adr == `ADIA_OFS_PSR;
  assign uv_ack = psr_wr && bus.dat_w[`ADIA_BIT_UVF]; // RQ8
  assign ht_ack = psr_wr && bus.dat_w[`ADIA_BIT_HTF]; // RQ14
  // edges of the live conditions; cranking mode hides under-voltage
  assign uv_rise = supply_input_low && !uv_prev_q && !cranking_en; // RQ10 RQ12
  assign ht_rise = high_temp_cond && !ht_prev_q; // RQ10

  // fixed priority, lowest bit wins, reported as bit number plus one
  always_comb
  begin
    vect = 4'h0;
    for (int i = `ADIA_NUM_SRC - 1; i >= 0; i--)
      if (pend_q[i])
        vect = 4'(i + 1); // RQ16 RQ4
  end

  // live condition copies and their edge history
  always_comb
  begin
    uv_prev_d = supply_input_low;
    ht_prev_d = high_temp_cond;
    uvf_d = supply_input_low; // RQ11
    htf_d = high_temp_cond; // RQ11
    plv_d = cranking_en && supply_input_low; // RQ12
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      uv_prev_q <= 1'b0;
      ht_prev_q <= 1'b0;
      uvf_q <= 1'b0;
      htf_q <= 1'b0;
      plv_q <= 1'b0;
    end
    else
    begin
      uv_prev_q <= uv_prev_d;
      ht_prev_q <= ht_prev_d;
      uvf_q <= uvf_d;
      htf_q <= htf_d;
      plv_q <= plv_d;
    end
  end

  // pending sources
  always_comb
  begin
    pend_d = pend_q;
    // other sources mirror their blocks; acknowledged in those blocks
    pend_d[`ADIA_NUM_SRC - 1:`ADIA_SRC_LT] = block_irq; // RQ7 RQ3 RQ5
    if (uv_ack && !supply_input_low)
      pend_d[`ADIA_SRC_UV] = 1'b0; // RQ8 RQ9
    if (ht_ack && !high_temp_cond)
      pend_d[`ADIA_SRC_HT] = 1'b0; // RQ14 RQ9
    // set wins over an acknowledge in the same cycle
    if (uv_rise || cranking_wake)
      pend_d[`ADIA_SRC_UV] = 1'b1; // RQ10 RQ13
    if (ht_rise)
      pend_d[`ADIA_SRC_HT] = 1'b1; // RQ10
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pend_q <= 14'h0000;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  // global masks, one bit per source
  always_comb
  begin
    msk_d = msk_q;
    if (wr && bus.adr == `ADIA_OFS_MSK_HI)
      msk_d[7:0] = bus.dat_w; // RQ6
    if (wr && bus.adr == `ADIA_OFS_MSK_LO)
      msk_d[13:8] = bus.dat_w[5:0]; // RQ6
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      msk_q <= `ADIA_MSK_RESET;
    end
    else
    begin
      msk_q <= msk_d;
    end
  end

  // interrupt line, a level over all unmasked pending sources
  always_comb
  begin
    irq_d = |(pend_d & msk_d); // RQ15 RQ1
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  // register answer; reads never touch the pending state
  always_comb
  begin
    ack_d = acc;
    rdat_d = 8'h00;
    if (rd)
    begin
      case (bus.adr)
        `ADIA_OFS_SRC_HI: rdat_d = pend_q[7:0]; // RQ2
        `ADIA_OFS_SRC_LO: rdat_d = {2'b00, pend_q[13:8]}; // RQ2
        `ADIA_OFS_VECT: rdat_d = {4'h0, vect}; // RQ4
        `ADIA_OFS_RSVD: rdat_d = 8'h00;
        `ADIA_OFS_MSK_HI: rdat_d = msk_q[7:0];
        `ADIA_OFS_MSK_LO: rdat_d = {2'b00, msk_q[13:8]};
        `ADIA_OFS_PSR:
        begin
          rdat_d[`ADIA_BIT_UVF] = uvf_q; // RQ11
          rdat_d[`ADIA_BIT_HTF] = htf_q; // RQ11
        end
        `ADIA_OFS_CTRL: rdat_d = {7'h00, cranking_en};
        default: rdat_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      rdat_q <= 8'h00;
    end
    else
    begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign bus.ack = ack_q;
  assign bus.dat_r = rdat_q;
  assign bus.die_interrupt_line = irq_q;
  assign undervoltage_flag = uvf_q;
  assign high_temp_flag = htf_q;
  assign precision_lv_en = plv_q;
endmodule

// *** hw/adia_host.sv ***
// microcontroller end: runs single register accesses over the die link
`timescale 1ns/1ps
`include "adia_consts.svh"
module adia_host (
  input wire logic sys_clk,
  input wire logic rst,
  adia_d2d_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_we,
  input wire logic [7:0] cmd_adr,
  input wire logic [7:0] cmd_wdat,
  output logic cmd_busy,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic irq_pending
);
  adia_pkg::adia_mst_state_t st_q, st_d;
  logic cyc_q, cyc_d, we_q, we_d, busy_q, busy_d, rv_q, rv_d, irq_q, irq_d;
  logic [7:0] adr_q, adr_d, wd_q, wd_d, rd_q, rd_d;

  always_comb
  begin
    st_d = st_q;
    cyc_d = cyc_q;
    we_d = we_q;
    adr_d = adr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    busy_d = busy_q;
    rv_d = 1'b0;
    irq_d = bus.die_interrupt_line;
    case (st_q)
      adia_pkg::ADIA_IDLE:
        if (cmd_valid)
        begin
          // acknowledging a source takes a separate write: under-voltage and high temperature to the status register, the others to their block
          st_d = adia_pkg::ADIA_REQ; // RQ3 RQ5 RQ8 RQ14
          cyc_d = 1'b1;
          we_d = cmd_we;
          adr_d = cmd_adr;
          wd_d = cmd_wdat;
          busy_d = 1'b1;
        end
      adia_pkg::ADIA_REQ:
        if (bus.ack)
        begin
          st_d = adia_pkg::ADIA_DONE;
          cyc_d = 1'b0;
          rd_d = we_q ? 8'h00 : bus.dat_r;
          rv_d = 1'b1;
        end
      adia_pkg::ADIA_DONE:
      begin
        st_d = adia_pkg::ADIA_IDLE;
        busy_d = 1'b0;
      end
      default: st_d = adia_pkg::ADIA_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q <= adia_pkg::ADIA_IDLE;
      cyc_q <= 1'b0;
      we_q <= 1'b0;
      adr_q <= 8'h00;
      wd_q <= 8'h00;
      rd_q <= 8'h00;
      busy_q <= 1'b0;
      rv_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      we_q <= we_d;
      adr_q <= adr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      busy_q <= busy_d;
      rv_q <= rv_d;
      irq_q <= irq_d;
    end
  end

  assign bus.cyc = cyc_q;
  assign bus.stb = cyc_q;
  assign bus.we = we_q;
  assign bus.adr = adr_q;
  assign bus.dat_w = wd_q;
  assign cmd_busy = busy_q;
  assign rsp_valid = rv_q;
  assign rsp_data = rd_q;
  assign irq_pending = irq_q;
endmodule

// *** testbench/adia_link_asserts.sv ***
// assertions on the die link signals
`timescale 1ns/1ps
module adia_link_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [7:0] adr,
  input wire logic [7:0] dat_r,
  input wire logic ack,
  input wire logic die_interrupt_line
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_req;
    cyc && stb && !ack;
  endsequence
  sequence s_rd(logic [7:0] a);
    ack && !we && adr == a;
  endsequence
  a_ack_answer: assert property (s_req |=> ack ##1 !ack)
    else $error("ack timing");
  a_req_hold: assert property (s_req |=> cyc && $stable(adr) && $stable(we))
    else $error("request moved");
  a_cyc_drop: assert property (ack |=> !cyc)
    else $error("cyc held");
  a_src_lo: assert property (s_rd(8'h09) |-> dat_r[7:6] == 2'h0)
    else $error("mirror lo top");
  a_vect_max: assert property (s_rd(8'h0a) |-> dat_r <= 8'h0e)
    else $error("vector range");
  a_rsvd_zero: assert property (s_rd(8'h0b) |-> dat_r == 8'h00)
    else $error("reserved");
  a_vect_idle: assert property (s_rd(8'h0a) ##0 dat_r == 8'h00 |-> !$past(die_interrupt_line))
    else $error("line idle");
  a_vect_line: assert property (s_rd(8'h0a) ##0 $past(die_interrupt_line) |-> dat_r != 8'h00)
    else $error("vector zero");
endmodule

// *** testbench/analog_die_interrupt_aggregator_tb.sv ***
// bench joining both ends of the aggregator
`timescale 1ns/1ps
module analog_die_interrupt_aggregator_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_we = 1'b0;
  logic [7:0] cmd_adr = 8'h00;
  logic [7:0] cmd_wdat = 8'h00;
  logic supply_input_low = 1'b0;
  logic high_temp_cond = 1'b0;
  logic cranking_en = 1'b0;
  logic cranking_wake = 1'b0;
  logic [11:0] block_irq = 12'h000;
  logic cmd_busy, rsp_valid, irq_pending, precision_lv_en;
  logic undervoltage_flag, high_temp_flag;
  logic [7:0] rsp_data;
  int err_total = 0;
  int compares = 0;
  always #2.5 sys_clk = ~sys_clk;
  adia_d2d_if bus ();
  adia_device adia_device_i (.sys_clk, .rst, .bus, .supply_input_low, .high_temp_cond, .cranking_en,
    .cranking_wake, .block_irq, .undervoltage_flag, .high_temp_flag, .precision_lv_en);
  adia_host adia_host_i (.sys_clk, .rst, .bus, .cmd_valid, .cmd_we, .cmd_adr, .cmd_wdat, .cmd_busy,
    .rsp_valid, .rsp_data, .irq_pending);
  adia_link_asserts adia_link_asserts_i (.sys_clk, .rst, .cyc(bus.cyc), .stb(bus.stb), .we(bus.we),
    .adr(bus.adr), .dat_r(bus.dat_r), .ack(bus.ack), .die_interrupt_line(bus.die_interrupt_line));
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {cmd_valid, cmd_we, cmd_adr, cmd_wdat} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    do @(negedge sys_clk); while (rsp_valid !== 1'b1);
    do @(negedge sys_clk); while (cmd_busy !== 1'b0);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rsp_data, e);
  endtask
  task pend(input logic [7:0] e);
    repeat (4) @(negedge sys_clk);
    chk({7'h00, irq_pending}, e);
  endtask
  task test_done;
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    test_done;
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(8'h0c, 8'hff);
    rdc(8'h0d, 8'h3f);
    rdc(8'h0b, 8'h00);
    rdc(8'h0a, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge sys_clk);
      block_irq <= 12'h001 << i;
      pend(8'h01);
      acc(1'b1, 8'h08, 8'h00);
      repeat (2) rdc(8'h0a, 8'(i + 3));
      rdc(8'h08, 8'(14'h0004 << i));
      rdc(8'h09, 8'((14'h0004 << i) >> 8));
    end
    @(posedge sys_clk);
    block_irq <= 12'hfff;
    rdc(8'h0a, 8'h03);
    acc(1'b1, 8'h0c, 8'h00);
    acc(1'b1, 8'h0d, 8'h00);
    pend(8'h00);
    acc(1'b1, 8'h0d, 8'h20);
    pend(8'h01);
    @(posedge sys_clk);
    block_irq <= 12'h000;
    pend(8'h00);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      {high_temp_cond, supply_input_low} <= 2'h1 << k;
      rdc(8'h0a, 8'(k + 1));
      rdc(8'h10, 8'h40 << k);
      chk({6'h00, high_temp_flag, undervoltage_flag}, 8'h01 << k);
      acc(1'b1, 8'h10, 8'h40 << k);
      rdc(8'h08, 8'h01 << k);
      rdc(8'h0a, 8'(k + 1));
      @(posedge sys_clk);
      {high_temp_cond, supply_input_low} <= 2'h0;
      rdc(8'h10, 8'h00);
      chk({6'h00, high_temp_flag, undervoltage_flag}, 8'h00);
      rdc(8'h08, 8'h01 << k);
      acc(1'b1, 8'h10, 8'h40 << k);
      rdc(8'h08, 8'h00);
      @(posedge sys_clk);
      {high_temp_cond, supply_input_low} <= 2'h1 << k;
      rdc(8'h08, 8'h01 << k);
      @(posedge sys_clk);
      {high_temp_cond, supply_input_low} <= 2'h0;
      acc(1'b1, 8'h10, 8'h40 << k);
    end
    @(posedge sys_clk);
    {cranking_en, supply_input_low} <= 2'h3;
    rdc(8'h11, 8'h01);
    rdc(8'h08, 8'h00);
    chk({7'h00, precision_lv_en}, 8'h01);
    @(posedge sys_clk);
    cranking_wake <= 1'b1;
    @(posedge sys_clk);
    cranking_wake <= 1'b0;
    rdc(8'h08, 8'h01);
    test_done;
  end
endmodule
